// ### uarx_map.svh
`ifndef UARX_MAP_SVH
`define UARX_MAP_SVH

// Register byte offsets
`define UARX_CTRL_OFS      12'h000
`define UARX_BAUD_OFS      12'h004
`define UARX_DATA_OFS      12'h008
`define UARX_STAT_OFS      12'h00c
`define UARX_IEN_OFS       12'h010

// Control fields
`define UARX_CTRL_RECEIVER_ENABLE     0
`define UARX_CTRL_ON       1
`define UARX_CTRL_MODE_LO  4
`define UARX_CTRL_MODE_HI  7
`define UARX_CTRL_HS       8
`define UARX_CTRL_FEEN     9
`define UARX_CTRL_PEEN     10
`define UARX_MODE_MAX      4'h3

// Status fields
`define UARX_ST_RXF        0
`define UARX_ST_FERR       1
`define UARX_ST_PERR       2
`define UARX_ST_OVR        3
`define UARX_ST_CNT_LO     4
`define UARX_ST_CNT_HI     5

// Interrupt enable fields
`define UARX_IEN_RX        0
`define UARX_IEN_GLOBAL    1

// Tick timing, normal speed
`define UARX_NS_LAST       4'hf
`define UARX_NS_S1         4'h1
`define UARX_NS_S2         4'h2
`define UARX_NS_M7         4'h7
`define UARX_NS_M8         4'h8
`define UARX_NS_M9         4'h9
// Tick timing, high speed
`define UARX_HS_LAST       4'h3
`define UARX_HS_MID        4'h2

`define UARX_BAUD_RST      16'h0000
`define UARX_FIFO_DEPTH    2

`endif

// ### uarx_pkg.sv
package uarx_pkg;
  typedef enum logic [2:0] {
    UARX_IDLE  = 3'b000,
    UARX_START = 3'b001,
    UARX_DATA  = 3'b011,
    UARX_STOP  = 3'b010
  } uarx_state_t;
endpackage

// ### uarx_receiver.sv
// The address map and the APB interface to the registers were decided locally.
`include "uarx_map.svh"
`timescale 1ns/1ps
`default_nettype none

module uarx_receiver
  import uarx_pkg::*;
#(
  parameter int DATA_BITS = 8,
  parameter int DIV_W     = 16
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial line
  input  wire logic        rx_line,
  // Parity error from an optional parity checker
  input  wire logic        parity_error_in,
  // Service outputs
  output logic             receive_flag,
  output logic             rx_irq
);

  // ----------------------------------------------------------------
  // Input synchroniser
  // ----------------------------------------------------------------
  logic rx_meta_q;
  logic rx_sync_q;
  logic rx_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_meta_q <= rx_line;
      rx_sync_q <= rx_meta_q;
      rx_prev_q <= rx_sync_q;
    end
  end

  // ----------------------------------------------------------------
  // Registers and bus decode
  // ----------------------------------------------------------------
  logic [10:0]          ctrl_q;
  logic [DIV_W-1:0]     baud_divisor_q;
  logic [1:0]           ien_q;
  logic                 framing_error_flag_q;
  logic                 parity_error_flag_q;
  logic                 overrun_q;
  logic [31:0]          prdata_q;

  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire sel_ctrl = (paddr == `UARX_CTRL_OFS);
  wire sel_baud = (paddr == `UARX_BAUD_OFS);
  wire sel_data = (paddr == `UARX_DATA_OFS);
  wire sel_stat = (paddr == `UARX_STAT_OFS);
  wire sel_ien  = (paddr == `UARX_IEN_OFS);
  wire mapped   = sel_ctrl | sel_baud | sel_data | sel_stat | sel_ien;
  wire data_rd  = acc & ~pwrite & sel_data;
  wire stat_wr  = wr & sel_stat;

  wire [3:0] mode = ctrl_q[`UARX_CTRL_MODE_HI:`UARX_CTRL_MODE_LO];
  wire hs_mode    = ctrl_q[`UARX_CTRL_HS];
  wire rx_active  = ctrl_q[`UARX_CTRL_RECEIVER_ENABLE] & ctrl_q[`UARX_CTRL_ON]
                  & (mode <= `UARX_MODE_MAX);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q         <= 11'h000;
      baud_divisor_q <= `UARX_BAUD_RST;
      ien_q          <= 2'h0;
    end else begin
      if (wr && sel_ctrl) begin
        ctrl_q <= pwdata[10:0];
      end
      if (wr && sel_baud) begin
        baud_divisor_q <= pwdata[DIV_W-1:0];
      end
      if (wr && sel_ien) begin
        ien_q <= pwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Baud tick generator
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt_q;
  logic             restart;
  wire              tick = rx_active && (div_cnt_q == '0);

  // One tick every baud_divisor+1 clocks, restarted on the start edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= '0;
    end else if (!rx_active || restart || div_cnt_q == '0) begin
      div_cnt_q <= baud_divisor_q;
    end else begin
      div_cnt_q <= div_cnt_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Data recovery
  // ----------------------------------------------------------------
  uarx_state_t              state_q;
  logic [3:0]               tcnt_q;
  logic [2:0]               smp_q;
  logic [3:0]               bitn_q;
  logic [DATA_BITS-1:0]     receive_shift_reg_q;
  logic                     push;
  logic                     push_ferr;

  wire [3:0] last_tick = hs_mode ? `UARX_HS_LAST : `UARX_NS_LAST;
  wire at_wrap   = tick && (tcnt_q == last_tick);
  wire maj_low   = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2]) | (smp_q[1] & smp_q[2]);
  // Decided bit value: majority in normal speed, single center sample in high speed
  wire bit_val   = hs_mode ? smp_q[0] : !maj_low;
  wire fall      = rx_prev_q & ~rx_sync_q;
  wire early_smp = tick && !hs_mode && (tcnt_q == `UARX_NS_S1 || tcnt_q == `UARX_NS_S2);
  wire mid_smp   = tick && (hs_mode ? (tcnt_q == `UARX_HS_MID)
                  : (tcnt_q == `UARX_NS_M7 || tcnt_q == `UARX_NS_M8
                     || tcnt_q == `UARX_NS_M9));
  wire last_bit  = (bitn_q == 4'(DATA_BITS - 1));

  assign restart = (state_q == UARX_IDLE) && fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q             <= UARX_IDLE;
      tcnt_q              <= 4'h0;
      smp_q               <= 3'h0;
      bitn_q              <= 4'h0;
      receive_shift_reg_q <= '0;
      push                <= 1'b0;
      push_ferr           <= 1'b0;
    end else begin
      push <= 1'b0;
      if (!rx_active) begin
        state_q <= UARX_IDLE;
      end else begin
        if (tick) begin
          tcnt_q <= at_wrap ? 4'h0 : tcnt_q + 4'h1;
        end
        // Samples shift in as "line is high" in smp_q[0] for high speed,
        // and as "line is low" for majority in normal speed
        if (mid_smp) begin
          smp_q <= {smp_q[1:0], hs_mode ? rx_sync_q : ~rx_sync_q};
        end
        case (state_q)
          UARX_IDLE: begin
            if (fall) begin
              state_q <= UARX_START;
              tcnt_q  <= 4'h0;
              smp_q   <= 3'h0;
              bitn_q  <= 4'h0;
            end
          end
          UARX_START: begin
            if (early_smp && tcnt_q == `UARX_NS_S2 && rx_sync_q && smp_q[2]) begin
              state_q <= UARX_IDLE;
            end else if (early_smp) begin
              smp_q[2] <= rx_sync_q;
            end else if (at_wrap) begin
              // Start must be low at center, else abort silently
              if (hs_mode ? smp_q[0] : !maj_low) begin
                state_q <= UARX_IDLE;
              end else begin
                state_q <= UARX_DATA;
              end
            end
          end
          UARX_DATA: begin
            if (at_wrap) begin
              receive_shift_reg_q <= {bit_val, receive_shift_reg_q[DATA_BITS-1:1]};
              bitn_q <= bitn_q + 4'h1;
              if (last_bit) begin
                state_q <= UARX_STOP;
              end
            end
          end
          UARX_STOP: begin
            // Decide at the sample point so the next start edge is not missed
            if (tick && tcnt_q == (hs_mode ? `UARX_HS_LAST : `UARX_NS_M9 + 4'h1)) begin
              push      <= 1'b1;
              push_ferr <= !bit_val;
              state_q   <= UARX_IDLE;
            end
          end
          default: state_q <= UARX_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-entry receive FIFO, hidden behind the buffer register
  // ----------------------------------------------------------------
  localparam int DEPTH = `UARX_FIFO_DEPTH;
  logic [DATA_BITS:0] fifo_q [DEPTH];
  logic               rd_ptr_q;
  logic               wr_ptr_q;
  logic [1:0]         count_q;

  wire fifo_full  = (count_q == 2'(DEPTH));
  wire fifo_empty = (count_q == 2'h0);
  wire do_pop     = data_rd && !fifo_empty;
  wire do_push    = push && (!fifo_full || do_pop);
  wire [DATA_BITS:0] head = fifo_q[rd_ptr_q];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q  <= 2'h0;
      fifo_q   <= '{default: '0};
    end else begin
      if (do_push) begin
        fifo_q[wr_ptr_q] <= {push_ferr, receive_shift_reg_q};
        wr_ptr_q         <= ~wr_ptr_q;
      end
      if (do_pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + 2'(do_push) - 2'(do_pop);
    end
  end

  // ----------------------------------------------------------------
  // Error flags; a hardware set wins over a software clear
  // ----------------------------------------------------------------
  wire head_ferr = !fifo_empty && head[DATA_BITS];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      framing_error_flag_q <= 1'b0;
      parity_error_flag_q  <= 1'b0;
      overrun_q            <= 1'b0;
    end else begin
      // Framing error tracks the character at the head of the FIFO
      framing_error_flag_q <= head_ferr;
      if (parity_error_in) begin
        parity_error_flag_q <= 1'b1;
      end else if (stat_wr && pwdata[`UARX_ST_PERR]) begin
        parity_error_flag_q <= 1'b0;
      end
      if (push && fifo_full && !do_pop) begin
        overrun_q <= 1'b1;
      end else if (stat_wr && pwdata[`UARX_ST_OVR]) begin
        overrun_q <= 1'b0;
      end
    end
  end

  // Head bit used directly so a faulty character never shows the flag for a cycle
  wire suppress = (head_ferr && ctrl_q[`UARX_CTRL_FEEN])
                | (parity_error_flag_q && ctrl_q[`UARX_CTRL_PEEN]);

  // Flag ignores writes to the status word, except that a parity error clear can raise it
  assign receive_flag = !fifo_empty && !suppress;
  assign rx_irq = receive_flag && ien_q[`UARX_IEN_RX] && ien_q[`UARX_IEN_GLOBAL];

  // ----------------------------------------------------------------
  // Read data; zero-wait answers
  // ----------------------------------------------------------------
  logic [31:0] stat_word;
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`UARX_ST_RXF]                   = receive_flag;
    stat_word[`UARX_ST_FERR]                  = framing_error_flag_q;
    stat_word[`UARX_ST_PERR]                  = parity_error_flag_q;
    stat_word[`UARX_ST_OVR]                   = overrun_q;
    stat_word[`UARX_ST_CNT_HI:`UARX_ST_CNT_LO] = count_q;
  end

  wire [31:0] rd_mux =
      sel_ctrl ? {21'h0, ctrl_q} :
      sel_baud ? 32'(baud_divisor_q) :
      sel_data ? (fifo_empty ? 32'h0 : 32'(head[DATA_BITS-1:0])) :
      sel_stat ? stat_word :
      sel_ien  ? {30'h0, ien_q} : 32'h0;

  // Registered in the setup cycle so the access phase sees stable data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;

endmodule

`default_nettype wire

// ### uarx_receiver_props.sv
`timescale 1ns/1ps
`default_nettype none
module uarx_props (
  // APB side
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Service side
  input wire logic        parity_error_in,
  input wire logic        receive_flag,
  input wire logic        rx_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc; psel && penable; endsequence
  sequence s_bad; psel && paddr > 12'h010 && paddr[1:0] == 2'b00; endsequence
  property p_rdy; s_acc |-> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("access without ready");
  property p_err; s_bad ##0 penable |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_ok; s_acc ##0 paddr <= 12'h010 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_only; pslverr |-> psel && penable; endproperty
  a_only: assert property (p_only) else $error("error outside access");
  property p_zero; s_bad ##0 !pwrite && !penable ##1 penable |-> prdata == 32'h0; endproperty
  a_zero: assert property (p_zero) else $error("unmapped read not zero");
  // Read data must not drift while the bus idles
  property p_hold; s_acc ##1 !psel [*2] |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data drifted");
  property p_irq; rx_irq |-> receive_flag; endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");
  property p_ifall; $fell(rx_irq) |-> !receive_flag || $past(pwrite && penable); endproperty
  a_ifall: assert property (p_ifall) else $error("irq dropped");
  // A bus access (a pop or a control write) or a parity hit are the only things that may lower the flag
  property p_fall;
    $fell(receive_flag) |-> $past(psel && penable) || $past(parity_error_in);
  endproperty
  a_fall: assert property (p_fall) else $error("flag lowered");
endmodule
bind uarx_receiver uarx_props i_uarx_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .parity_error_in(parity_error_in), .receive_flag(receive_flag), .rx_irq(rx_irq)
);
`default_nettype wire

// ### uarx_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module uarx_tx_model (
  // Clock
  input  wire logic pclk,
  // Serial line, idles high
  output var logic  rx_line
);
  initial begin
    rx_line = 1'b1;
  end
  task automatic send(input logic [7:0] d, input logic stp, input int bc);
    @(posedge pclk) rx_line <= 1'b0;
    repeat (bc) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      rx_line <= d[i];
      repeat (bc) @(posedge pclk);
    end
    rx_line <= stp;
    repeat (bc) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (2 * bc) @(posedge pclk);
  endtask
  // Low pulse of n clocks, too short for a start bit
  task automatic pulse(input int n);
    @(posedge pclk) rx_line <= 1'b0;
    repeat (n) @(posedge pclk);
    rx_line <= 1'b1;
    repeat (400) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ### uart_async_receiver_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module uart_async_receiver_tb_top;
  localparam int NB = 32;
  localparam int HB = 8;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        parity_error_in;
  logic        pready;
  logic        pslverr;
  logic        receive_flag;
  logic        rx_irq;
  logic        err;
  logic        ok;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [7:0]  b [3];
  logic [31:0] cv [7] = '{32'h3, 32'h13, 32'h23, 32'h33, 32'h43, 32'h2, 32'h1};
  wire logic   rx_line;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          seed = 19;
  uarx_receiver i_uarx_receiver (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_line(rx_line),
    .parity_error_in(parity_error_in), .receive_flag(receive_flag), .rx_irq(rx_irq));
  uarx_tx_model i_uarx_tx_model (.pclk(pclk), .rx_line(rx_line));
  // ----
  // Clock and watchdog
  // ----
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // ----
  // Bus, compare and report
  // ----
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t bit %b expected %b", $time, g, e);
    end
  endtask
  function automatic logic [31:0] st(input logic f, fe, pe, ov, input logic [1:0] n);
    return {26'h0, n, ov, pe, fe, f};
  endfunction
  task automatic report_and_stop();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, parity_error_in} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 12'h004, 32'h1);
    apb(1'b1, 12'h010, 32'h1);
    for (int k = 0; k < 7; k++) begin
      ok = cv[k][1:0] == 2'b11 && cv[k][7:4] <= 4'h3;
      apb(1'b1, 12'h000, cv[k]);
      b[0] = 8'($random(seed));
      i_uarx_tx_model.send(b[0], 1'b1, NB);
      apb(1'b0, 12'h00c, 32'h0);
      chk(rd, st(ok, 1'b0, 1'b0, 1'b0, {1'b0, ok}));
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, ok ? {24'h0, b[0]} : 32'h0);
    end
    apb(1'b1, 12'h000, 32'h3);
    for (int k = 0; k < 3; k++) begin
      b[k] = 8'($random(seed));
      i_uarx_tx_model.send(b[k], 1'b1, NB);
    end
    chkb(rx_irq, 1'b0);
    apb(1'b1, 12'h00c, 32'h1);
    chkb(receive_flag, 1'b1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, st(1'b1, 1'b0, 1'b0, 1'b1, 2'd2));
    apb(1'b1, 12'h010, 32'h3);
    chkb(rx_irq, 1'b1);
    apb(1'b1, 12'h00c, 32'h8);
    for (int k = 0; k < 2; k++) begin
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, {24'h0, b[k]});
    end
    apb(1'b1, 12'h00c, 32'h1);
    chkb(receive_flag, 1'b0);
    apb(1'b1, 12'h000, 32'h303);
    b[0] = 8'($random(seed));
    b[1] = 8'($random(seed));
    i_uarx_tx_model.send(b[0], 1'b0, HB);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, st(1'b0, 1'b1, 1'b0, 1'b0, 2'd1));
    i_uarx_tx_model.send(b[1], 1'b1, HB);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, {24'h0, b[0]});
    chkb(receive_flag, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, {24'h0, b[1]});
    apb(1'b1, 12'h000, 32'h403);
    i_uarx_tx_model.pulse(1);
    i_uarx_tx_model.pulse(8);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    i_uarx_tx_model.send(b[2], 1'b1, NB);
    @(posedge pclk) parity_error_in <= 1'b1;
    @(posedge pclk) parity_error_in <= 1'b0;
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, st(1'b0, 1'b0, 1'b1, 1'b0, 2'd1));
    apb(1'b1, 12'h00c, 32'h4);
    chkb(receive_flag, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, {24'h0, b[2]});
    apb(1'b0, 12'h020, 32'h0);
    chk(rd, 32'h0);
    chkb(err, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
